// file: shared/pac_cfg.svh
// permission checker constants: field positions, codes, register offsets
// assumes inclusion by bare name from package and core
`ifndef PAC_CFG_SVH
`define PAC_CFG_SVH
`define PAC_LEVELS        4
`define PAC_CPL_W         2
`define PAC_CPL_USER      2'h3
`define PAC_ADDR_W        4
`define PAC_OFF_STATUS    4'h0
`define PAC_OFF_MASK      4'h4
`define PAC_OFF_CTRL      4'h8
`define PAC_OFF_COUNT     4'hc
`define PAC_EV_W          3
`define PAC_EV_PF         0
`define PAC_EV_GP         1
`define PAC_EV_SS         2
`define PAC_MASK_RST      3'h0
`define PAC_CTRL_WP_BIT   0
`define PAC_CTRL_RST      1'h0
`endif

// file: shared/pac_pkg.sv
// types shared by the permission checker and its surroundings
// assumes pac_cfg.svh on the include path
`default_nettype none
`include "pac_cfg.svh"
package pac_pkg;
	typedef enum logic [1:0] {
		PAC_EXC_NONE = 2'h0,
		PAC_EXC_PF   = 2'h1,
		PAC_EXC_GP   = 2'h2,
		PAC_EXC_SS   = 2'h3
	} pac_exc_t;
	typedef struct packed {
		logic userLevel;
		logic readWrite;
	} pac_attr_t;
	typedef struct packed {
		logic                    valid;
		logic                    isWrite;
		logic [`PAC_CPL_W-1:0]   currentPrivilegeLevel;
		logic                    segFault;
		logic                    segIsStack;
		pac_attr_t [`PAC_LEVELS-1:0] attr;
	} pac_req_t;
	typedef struct packed {
		logic     valid;
		logic     permit;
		logic     doAccess;
		pac_exc_t exc;
		logic     userPage;
		logic     pageWritable;
	} pac_rsp_t;
endpackage : pac_pkg
`default_nettype wire

// file: core/pac_checker.sv
// page access permission checker: one decision per access, one cycle later
// assumes requests come from the pipeline synchronous to mclk
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`default_nettype none
`include "pac_cfg.svh"
//
// Summary of operation
// [R1] all levels user gives a user page open to user and supervisor
// [R2] user page read-only if any level read-only, writable only if all
// [R3] protect on: any supervisor level gives supervisor-only page
// [R4] protect on: supervisor page writable only when every level grants write
// [R5] protect off: supervisor writes user read-only pages freely
// [R6] protect on: supervisor write to read-only user page refused
// [R7] segment check evaluated first, page check afterwards
// [R8] segment violation overrides the page fault; userPage and pageWritable still reported
// [R9] any violation raises exception and suppresses the access
// [R10] segment violation reported as general-protection or stack fault
// [R11] page violation reported as page fault
// [R12] protect off: supervisor page for levels 0-2, always writable
// [R13] supervisor page accessed at level 3 raises page fault
// [R14] user write to read-only page faults regardless of protect
// [R15] inputs access type, privilege, attributes; output permit or fault
module pac_checker (
	input  wire logic                      mclk,    // core clock
	input  wire logic                      rst,     // async reset, high
	input  wire pac_pkg::pac_req_t         req,     // access to check
	output var  pac_pkg::pac_rsp_t         rsp,     // decision
	input  wire logic [`PAC_ADDR_W-1:0]    regAddr, // register address
	input  wire logic [31:0]               regWdata, // write data
	input  wire logic                      regWr,   // write strobe
	input  wire logic                      regRd,   // read strobe
	output logic      [31:0]               regRdata, // read data
	output logic                           irq      // level interrupt
);
	import pac_pkg::*;

	logic                 writeProtectEnable;
	logic [`PAC_EV_W-1:0] status_ff;
	logic [`PAC_EV_W-1:0] mask_ff;
	logic [31:0]          count_ff;
	logic                 ctrl_ff;
	pac_rsp_t             rsp_ff;
	logic [31:0]          rdata_ff;
	logic                 irq_ff;

	logic allUser;
	logic allRw;
	logic isUserCpl;
	logic pageFault;
	logic [`PAC_EV_W-1:0] events;
	pac_rsp_t nxt_rsp;
	logic [`PAC_EV_W-1:0] nxt_status;

	assign writeProtectEnable = ctrl_ff;

	// combined attributes across the hierarchy
	always_comb begin
		allUser = 1'b1;
		allRw   = 1'b1;
		for (int i = 0; i < `PAC_LEVELS; i++) begin
			allUser = allUser & req.attr[i].userLevel; // R1
			allRw   = allRw & req.attr[i].readWrite;   // R2
		end
	end

	assign isUserCpl = (req.currentPrivilegeLevel == `PAC_CPL_USER);

	// page decision
	always_comb begin
		pageFault = 1'b0;
		if (!allUser) begin
			if (isUserCpl)
				pageFault = 1'b1; // R3 R12 R13
			else if (req.isWrite && !allRw && writeProtectEnable)
				pageFault = 1'b1; // R4
		end else begin
			if (req.isWrite && !allRw) begin
				if (isUserCpl)
					pageFault = 1'b1; // R14
				else if (writeProtectEnable)
					pageFault = 1'b1; // R6
				else
					pageFault = 1'b0; // R5
			end
		end
	end

	// segment first, page only when segment clean
	always_comb begin
		nxt_rsp              = '0;
		nxt_rsp.valid        = req.valid;
		nxt_rsp.userPage     = allUser; // R1
		nxt_rsp.pageWritable = allRw | (!writeProtectEnable & !isUserCpl);
		if (req.valid) begin
			if (req.segFault) begin // R7 R8
				nxt_rsp.exc = req.segIsStack ? PAC_EXC_SS
				                             : PAC_EXC_GP; // R10
			end else if (pageFault) begin
				nxt_rsp.exc = PAC_EXC_PF; // R11
			end else begin
				nxt_rsp.permit   = 1'b1; // R15
				nxt_rsp.doAccess = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rsp_ff <= '0;
		else
			rsp_ff <= nxt_rsp; // R9
	end
	assign rsp = rsp_ff;

	assign events[`PAC_EV_PF] = nxt_rsp.exc == PAC_EXC_PF;
	assign events[`PAC_EV_GP] = nxt_rsp.exc == PAC_EXC_GP;
	assign events[`PAC_EV_SS] = nxt_rsp.exc == PAC_EXC_SS;

	// sticky status, write one to clear, set wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			status_ff <= '0;
		else if (regWr && regAddr == `PAC_OFF_STATUS)
			status_ff <= (status_ff & ~regWdata[`PAC_EV_W-1:0]) | events;
		else
			status_ff <= status_ff | events;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			mask_ff <= `PAC_MASK_RST;
		else if (regWr && regAddr == `PAC_OFF_MASK)
			mask_ff <= regWdata[`PAC_EV_W-1:0];
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ctrl_ff <= `PAC_CTRL_RST;
		else if (regWr && regAddr == `PAC_OFF_CTRL)
			ctrl_ff <= regWdata[`PAC_CTRL_WP_BIT];
	end

	// permitted access counter, write clears
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			count_ff <= '0;
		else if (regWr && regAddr == `PAC_OFF_COUNT)
			count_ff <= '0;
		else if (nxt_rsp.doAccess)
			count_ff <= count_ff + 32'h1;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rdata_ff <= '0;
		else if (regRd) begin
			unique case (regAddr)
				`PAC_OFF_STATUS: rdata_ff <= {29'h0, status_ff};
				`PAC_OFF_MASK:   rdata_ff <= {29'h0, mask_ff};
				`PAC_OFF_CTRL:   rdata_ff <= {31'h0, ctrl_ff};
				`PAC_OFF_COUNT:  rdata_ff <= count_ff;
				default:         rdata_ff <= 32'h0;
			endcase
		end else
			rdata_ff <= 32'h0;
	end
	assign regRdata = rdata_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(nxt_status & mask_ff);
	end
	assign irq = irq_ff;

	always_comb begin
		nxt_status = status_ff | events;
		if (regWr && regAddr == `PAC_OFF_STATUS)
			nxt_status = (status_ff & ~regWdata[`PAC_EV_W-1:0]) | events;
	end

	chk_seg_no_page: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && req.segFault) |=> rsp.exc != PAC_EXC_PF) // R8
		else $error("segment fault reported as page fault");
	chk_seg_class: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && req.segFault && req.segIsStack)
		|=> rsp.exc == PAC_EXC_SS) // R10
		else $error("stack segment fault class wrong");
	chk_fault_no_access: assert property (@(posedge mclk) disable iff (rst)
		rsp.exc != PAC_EXC_NONE |-> !rsp.doAccess && !rsp.permit) // R9
		else $error("access performed despite fault");
	chk_user_cpl_sup: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && isUserCpl && !allUser)
		|=> rsp.exc == PAC_EXC_PF) // R13
		else $error("user access to supervisor page not faulted");
	chk_user_ro_write: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && isUserCpl && req.isWrite && !allRw)
		|=> rsp.exc == PAC_EXC_PF) // R14
		else $error("user write to read-only page not faulted");
	chk_wp_off_sup: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && !isUserCpl && !writeProtectEnable)
		|=> rsp.permit) // R5
		else $error("supervisor access refused with protect off");
	chk_wp_on_sup: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && !isUserCpl && writeProtectEnable
		 && req.isWrite && !allRw) |=> rsp.exc == PAC_EXC_PF) // R6
		else $error("supervisor write to read-only page allowed");
	chk_user_rw_ok: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && allUser && allRw)
		|=> rsp.permit && rsp.userPage) // R1
		else $error("full user read-write page refused");
	chk_read_ok: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && !req.isWrite && !isUserCpl)
		|=> rsp.doAccess) // R3
		else $error("supervisor read refused");
	chk_sup_wr_ok: assert property (@(posedge mclk) disable iff (rst)
		(req.valid && !req.segFault && !isUserCpl && allRw)
		|=> $past(req.valid) && rsp.permit) // R4
		else $error("writable page refused to supervisor");

	// response framing
	chk_rsp_follows: assert property (@(posedge mclk) disable iff (rst) // R15
		req.valid
		|=> rsp.valid)
		else $error("request without decision");

	chk_idle_quiet: assert property (@(posedge mclk) disable iff (rst) // R15
		!req.valid
		|=> !rsp.valid && !rsp.permit)
		else $error("decision without request");

	chk_idle_no_exc: assert property (@(posedge mclk) disable iff (rst) // R9
		!req.valid
		|=> rsp.exc == PAC_EXC_NONE && !rsp.doAccess)
		else $error("exception or access without request");

	chk_permit_access: assert property (@(posedge mclk) disable iff (rst) // R9
		rsp.permit
		|-> rsp.doAccess && rsp.valid)
		else $error("permit without access");

	chk_clean_permit: assert property (@(posedge mclk) disable iff (rst) // R15
		rsp.valid && rsp.exc == PAC_EXC_NONE
		|-> rsp.permit)
		else $error("clean access not permitted");

	// fault classes
	chk_gp_class: assert property (@(posedge mclk) disable iff (rst) // R10
		req.valid && req.segFault && !req.segIsStack
		|=> rsp.exc == PAC_EXC_GP)
		else $error("general segment fault class wrong");

	chk_seg_skips_page: assert property (@(posedge mclk) disable iff (rst) // R8
		req.valid && req.segFault
		|=> !rsp.permit && !rsp.doAccess)
		else $error("access performed after segment fault");

	chk_seg_first: assert property (@(posedge mclk) disable iff (rst) // R7
		req.valid && req.segFault
		|=> rsp.exc == PAC_EXC_GP || rsp.exc == PAC_EXC_SS)
		else $error("segment fault not reported first");

	chk_page_pf_only: assert property (@(posedge mclk) disable iff (rst) // R11
		req.valid && !req.segFault
		|=> rsp.exc == PAC_EXC_NONE || rsp.exc == PAC_EXC_PF)
		else $error("page violation with wrong class");

	// page protection cases
	chk_user_read: assert property (@(posedge mclk) disable iff (rst) // R1
		req.valid && !req.segFault && allUser && !req.isWrite
		|=> rsp.permit)
		else $error("read of user page refused");

	chk_user_ro_wr: assert property (@(posedge mclk) disable iff (rst) // R2
		req.valid && !req.segFault && allUser && isUserCpl && req.isWrite
		&& !allRw |=> rsp.exc == PAC_EXC_PF)
		else $error("user write to read-only user page allowed");

	chk_user_rw_wr: assert property (@(posedge mclk) disable iff (rst) // R2
		req.valid && !req.segFault && allUser && allRw && req.isWrite
		|=> rsp.permit)
		else $error("write to read-write user page refused");

	chk_sup_rd_wp_on: assert property (@(posedge mclk) disable iff (rst) // R3
		req.valid && !req.segFault && !allUser && !isUserCpl
		&& writeProtectEnable && !req.isWrite |=> rsp.permit)
		else $error("supervisor read of supervisor page refused");

	chk_sup_rw_wp_on: assert property (@(posedge mclk) disable iff (rst) // R4
		req.valid && !req.segFault && !allUser && !isUserCpl
		&& writeProtectEnable && req.isWrite && allRw |=> rsp.permit)
		else $error("write to writable supervisor page refused");

	chk_sup_ro_wp_on: assert property (@(posedge mclk) disable iff (rst) // R4
		req.valid && !req.segFault && !allUser && !isUserCpl
		&& writeProtectEnable && req.isWrite && !allRw |=> rsp.exc == PAC_EXC_PF)
		else $error("write to read-only supervisor page allowed");

	chk_user_ro_wp_off: assert property (@(posedge mclk) disable iff (rst) // R5
		req.valid && !req.segFault && allUser && !isUserCpl
		&& !writeProtectEnable && req.isWrite && !allRw |=> rsp.permit)
		else $error("supervisor write to user page refused");

	chk_user_ro_wp_on: assert property (@(posedge mclk) disable iff (rst) // R6
		req.valid && !req.segFault && allUser && !isUserCpl
		&& writeProtectEnable && req.isWrite && !allRw |=> rsp.exc == PAC_EXC_PF)
		else $error("supervisor write to read-only user page allowed");

	chk_sup_wr_wp_off: assert property (@(posedge mclk) disable iff (rst) // R12
		req.valid && !req.segFault && !allUser && !isUserCpl
		&& !writeProtectEnable && req.isWrite |=> rsp.permit)
		else $error("supervisor write with protect off refused");

	chk_sup_user_any: assert property (@(posedge mclk) disable iff (rst) // R13
		req.valid && !req.segFault && !allUser && isUserCpl
		|=> !rsp.permit && !rsp.doAccess)
		else $error("user level reached supervisor page");

	chk_user_wr_prot: assert property (@(posedge mclk) disable iff (rst) // R14
		req.valid && !req.segFault && isUserCpl && req.isWrite && !allRw
		&& writeProtectEnable |=> rsp.exc == PAC_EXC_PF)
		else $error("user write to read-only page allowed");

	chk_user_page_flag: assert property (@(posedge mclk) disable iff (rst) // R1
		req.valid
		|=> rsp.userPage == $past(allUser))
		else $error("user page flag wrong");

	// status and interrupt
	chk_status_sticky: assert property (@(posedge mclk) disable iff (rst) // R9
		!(regWr && regAddr == `PAC_OFF_STATUS)
		|=> (status_ff & $past(status_ff)) == $past(status_ff))
		else $error("status bit lost without clear");

	chk_status_pf: assert property (@(posedge mclk) disable iff (rst) // R11
		rsp.valid && rsp.exc == PAC_EXC_PF
		|-> status_ff[`PAC_EV_PF])
		else $error("page fault not recorded");

	chk_irq_level: assert property (@(posedge mclk) disable iff (rst) // R9
		1'b1
		|=> irq == $past(|(nxt_status & mask_ff)))
		else $error("interrupt level wrong");
endmodule : pac_checker
`default_nettype wire

// file: verification/pac_pipe_model.sv
// pipeline model: issues checked accesses on request of the bench
// assumes pac_pkg compiled first; bench calls send and idle
`default_nettype none
module pac_pipe_model (
	input  wire logic       mclk, // core clock
	output var  pac_pkg::pac_req_t req // access to the checker
);
	timeunit 1ns;
	timeprecision 1ps;
	import pac_pkg::*;
	initial req = '0;
	task automatic send(input pac_req_t r);
		@(posedge mclk);
		req <= r;
	endtask : send
	// released fields show the inverse, never the last access
	task automatic idle();
		pac_req_t t;
		@(posedge mclk);
		t = ~req;
		t.valid = 1'b0;
		req <= t;
	endtask : idle
endmodule : pac_pipe_model
`default_nettype wire

// file: verification/pac_checker_tb.sv
// bench: sweeps every access class, then status, mask, irq and count
// assumes pac_pkg, pac_checker and pac_pipe_model compiled first
`default_nettype none
`include "pac_cfg.svh"
module pac_checker_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pac_pkg::*;
	logic mclk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, irq;
	logic [`PAC_ADDR_W-1:0] regAddr = '0;
	logic [31:0] regWdata = '0, regRdata, nPermit = '0;
	pac_req_t req;
	pac_rsp_t rsp;
	int err_total = 0, n_compared = 0, cyc = 0;
	pac_exc_t expE[$];
	logic expU[$];
	logic expW[$];
	always #10 mclk = ~mclk;
	pac_pipe_model pipe (.mclk(mclk), .req(req));
	pac_checker uut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .irq(irq));
	task automatic complete_run();
		$display("errors %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run
	task automatic cmp_word(string n, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : cmp_word
	task automatic cmp_exc(string n, pac_exc_t e, pac_exc_t s);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask : cmp_exc
	task automatic wr(logic [`PAC_ADDR_W-1:0] a, logic [31:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(logic [`PAC_ADDR_W-1:0] a, logic [31:0] e);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1 cmp_word("regRdata", e, regRdata);
	endtask : rd
	function automatic pac_exc_t exp_exc(logic wp, pac_req_t r);
		logic usr = 1'b1, rwAll = 1'b1, sup;
		for (int k = 0; k < `PAC_LEVELS; k++) begin
			usr &= r.attr[k].userLevel;
			rwAll &= r.attr[k].readWrite;
		end
		sup = r.currentPrivilegeLevel != `PAC_CPL_USER;
		if (r.segFault) return r.segIsStack ? PAC_EXC_SS : PAC_EXC_GP;
		if (!usr && !sup) return PAC_EXC_PF;
		if (r.isWrite && !rwAll && (!sup || wp)) return PAC_EXC_PF;
		return PAC_EXC_NONE;
	endfunction : exp_exc
	// back to back: every level pattern, privilege, type, segment result
	task automatic sweep(logic wp);
		pac_req_t r;
		for (int i = 0; i < 8192; i++) begin
			r = '0;
			r.valid = 1'b1;
			{r.segIsStack, r.segFault, r.isWrite} = i[12:10];
			r.currentPrivilegeLevel = i[9:8];
			r.attr = i[7:0];
			expE.push_back(exp_exc(wp, r));
			expU.push_back(&{r.attr[3].userLevel, r.attr[2].userLevel,
				r.attr[1].userLevel, r.attr[0].userLevel});
			expW.push_back(&{r.attr[3].readWrite, r.attr[2].readWrite,
				r.attr[1].readWrite, r.attr[0].readWrite}
				| (!wp && r.currentPrivilegeLevel != `PAC_CPL_USER));
			if (expE[$] == PAC_EXC_NONE) nPermit++;
			pipe.send(r);
		end
		pipe.idle();
	endtask : sweep
	always @(posedge mclk) begin
		#1;
		if (rsp.valid === 1'b1 && expE.size() == 0)
			cmp_word("rsp.valid", 32'h0, 32'h1);
		else if (rsp.valid === 1'b1) begin
			cmp_exc("rsp.exc", expE[0], rsp.exc);
			cmp_word("permit", expE[0] == PAC_EXC_NONE, rsp.permit);
			cmp_word("doAccess", expE[0] == PAC_EXC_NONE, rsp.doAccess);
			cmp_word("userPage", expU[0], rsp.userPage);
			cmp_word("pageWritable", expW[0], rsp.pageWritable);
			void'(expE.pop_front());
			void'(expU.pop_front());
			void'(expW.pop_front());
		end
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		rd(4'h2, 32'h0);
		rd(`PAC_OFF_MASK, 32'h0);
		rd(`PAC_OFF_CTRL, 32'h0);
		wr(`PAC_OFF_COUNT, 32'h0);
		sweep(1'b0);
		wr(`PAC_OFF_CTRL, 32'h1);
		sweep(1'b1);
		repeat (3) @(posedge mclk);
		cmp_word("pending", 32'h0, expE.size());
		rd(`PAC_OFF_STATUS, 32'h7);
		rd(`PAC_OFF_COUNT, nPermit);
		cmp_word("irq", 32'h0, irq);
		wr(`PAC_OFF_MASK, 32'h1);
		repeat (2) @(posedge mclk);
		#1 cmp_word("irq", 32'h1, irq);
		wr(`PAC_OFF_STATUS, 32'h1);
		rd(`PAC_OFF_STATUS, 32'h6);
		cmp_word("irq", 32'h0, irq);
		complete_run();
	end
endmodule : pac_checker_tb
`default_nettype wire
